//--- design/rscc_map.svh
// constants, field positions, reset values and vectors of the return stack context control block
// Summary of operation
// - with the stack fault reset enable set, a full or underflow condition first sets its flag and then resets the device.
// - with the stack fault reset enable clear, a full or underflow condition sets its flag and does not reset the device.
// - the full and underflow flags hold until software clears them or a power-on reset occurs.
// - a one-entry shadow context stack keeps status, working and bank select values and software cannot reach it.
// - every interrupt vectoring loads the shadow context stack with the current status, working and bank select values.
// - a fast return from interrupt copies the shadow context back into status, working and bank select.
// - a fast call saves status, working and bank select into the shadow context stack while pushing the return address.
// - a fast return restores status, working and bank select from the shadow context stack while popping.
// - a high priority interrupt during low priority service overwrites the shadow context stack.
// - adding the working register to the program counter low byte advances the program counter by that many bytes.
// - a return with literal pops the return address and places its 8-bit literal in the working register.
// - an interrupt wake-up with a global enable set pushes the current program counter and advances the stack pointer.
// - an interrupt wake-up with a global enable set loads the program counter with the high or low priority vector.
// - a wake-up leaves at least one cause bit set in the interrupt control or request registers.
`ifndef RSCC_MAP_SVH
`define RSCC_MAP_SVH
`define RSCC_PC_W          21
`define RSCC_STACK_DEPTH   31
`define RSCC_SP_W          5
`define RSCC_VEC_HIGH      21'h000008
`define RSCC_VEC_LOW       21'h000018
`define RSCC_PC_RESET      21'h000000
`define RSCC_BYTE_RESET    8'h00
`define RSCC_SP_RESET      5'h00
`define RSCC_INSTR_BYTES   21'h000002
`define RSCC_CAUSE_W       8
// register map over the bus
`define RSCC_OFF_CTRL      32'h00000000
`define RSCC_OFF_STACK     32'h00000004
`define RSCC_OFF_IRQ_STAT  32'h00000008
`define RSCC_OFF_IRQ_MASK  32'h0000000C
`define RSCC_OFF_PC        32'h00000010
`define RSCC_OFF_CAUSE     32'h00000014
// stack status bits
`define RSCC_BIT_FULL      7
`define RSCC_BIT_UNF       6
// interrupt status bits
`define RSCC_IRQ_FULL      0
`define RSCC_IRQ_UNF       1
`define RSCC_IRQ_WAKE      2
`define RSCC_IRQ_W         3
`endif

//--- design/rscc_pkg.sv
// types of the return stack context control block
package rscc_pkg;
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] working;
        logic [7:0] bank;
    } rscc_ctx_t;
    typedef struct packed {
        logic       call;
        logic       call_fast;
        logic       ret;
        logic       ret_fast;
        logic       return_from_interrupt_op;
        logic       return_from_interrupt_op_fast;
        logic       return_with_literal_op;
        logic       add_pcl;
        logic       irq_high;
        logic       irq_low;
        logic       wake_irq;
        logic       wake_high;
    } rscc_op_t;
    typedef enum logic [2:0] {
        RSCC_RUN   = 3'b001,
        RSCC_FAULT = 3'b010,
        RSCC_RESET = 3'b100
    } rscc_state_t;
endpackage : rscc_pkg

//--- design/rscc_ahb_slave.sv
// AHB-Lite slave front end that turns bus transfers into register strobes
`timescale 1ns/1ps
`include "rscc_map.svh"
module rscc_ahb_slave (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // register side
    output logic             wr_en,
    output logic             rd_en,
    output logic [31:0]      reg_addr,
    output logic [31:0]      wr_data,
    input  wire logic [31:0] rd_data
);
    logic        dphase_reg;
    logic        dwrite_reg;
    logic [31:0] daddr_reg;
    wire         take = hsel && hready && htrans[1];

    // read data registered one cycle later, so the top can present it straight from a flop
    always_ff @(posedge mclk) begin
        if (reset) begin
            dphase_reg <= 1'b0;
            dwrite_reg <= 1'b0;
            daddr_reg  <= 32'h00000000;
            hrdata     <= 32'h00000000;
        end else begin
            dphase_reg <= take;
            dwrite_reg <= take && hwrite;
            if (take) begin
                daddr_reg <= haddr;
            end
            hrdata <= (take && !hwrite) ? rd_data : 32'h00000000;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_en     = dphase_reg && dwrite_reg;
    assign rd_en     = take && !hwrite;
    assign reg_addr  = wr_en ? daddr_reg : haddr;
    assign wr_data   = hwdata;
endmodule : rscc_ahb_slave

//--- design/rscc_core.sv
// return stack, shadow context and vectoring logic of the core
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "rscc_map.svh"
module rscc_core #(
    parameter int DEPTH = `RSCC_STACK_DEPTH
) (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // bus
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // sequencer operations
    input  wire rscc_pkg::rscc_op_t    op,
    input  wire logic [7:0]            literal,
    input  wire logic [`RSCC_PC_W-1:0] call_target,
    input  wire rscc_pkg::rscc_ctx_t   live_ctx,
    input  wire logic [`RSCC_CAUSE_W-1:0] wake_cause,
    // configuration strap and enables
    input  wire logic                  stack_fault_reset_enable,
    input  wire logic                  high_priority_global_enable,
    input  wire logic                  low_priority_global_enable,
    // results to the core
    output logic [`RSCC_PC_W-1:0]      pc_out,
    output rscc_pkg::rscc_ctx_t        restore_ctx,
    output logic                       restore_valid,
    output logic [7:0]                 working_register,
    output logic                       working_valid,
    output logic                       device_reset,
    output logic                       irq
);
    logic [`RSCC_PC_W-1:0]   stack_mem [DEPTH];
    logic [`RSCC_SP_W-1:0]   sp_reg;
    logic [`RSCC_PC_W-1:0]   pc_reg;
    rscc_pkg::rscc_ctx_t     shadow_context_stack;
    logic                    full_reg;
    logic                    unf_reg;
    logic                    sfre_reg;
    logic [`RSCC_IRQ_W-1:0]  irq_stat_reg;
    logic [`RSCC_IRQ_W-1:0]  irq_mask_reg;
    logic [`RSCC_CAUSE_W-1:0] cause_reg;
    rscc_pkg::rscc_state_t   state_reg;
    logic                    wr_en;
    logic                    rd_en;
    logic [31:0]             reg_addr;
    logic [31:0]             wr_data;
    logic [31:0]             rd_data;

    rscc_ahb_slave u_bus (
        .mclk      (mclk),
        .reset     (reset),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .wr_en     (wr_en),
        .rd_en     (rd_en),
        .reg_addr  (reg_addr),
        .wr_data   (wr_data),
        .rd_data   (rd_data)
    );

    // operation decode
    wire run       = (state_reg == rscc_pkg::RSCC_RUN);
    wire wake_vec  = op.wake_irq && (high_priority_global_enable || low_priority_global_enable);
    wire irq_vec   = op.irq_high || op.irq_low || wake_vec;
    wire push      = run && (op.call || op.call_fast || irq_vec);
    wire pop       = run && !push && (op.ret || op.ret_fast || op.return_from_interrupt_op || op.return_from_interrupt_op_fast || op.return_with_literal_op);
    wire at_full   = (sp_reg == `RSCC_SP_W'(DEPTH));
    wire at_empty  = (sp_reg == `RSCC_SP_W'(0));
    wire full_ev   = push && at_full;
    wire unf_ev    = pop && at_empty;
    wire fault_ev  = full_ev || unf_ev;
    wire save_ctx  = push && !full_ev && (op.call_fast || irq_vec);
    wire restore   = pop && !unf_ev && (op.ret_fast || op.return_from_interrupt_op_fast);
    wire high_vec  = op.irq_high || (wake_vec && op.wake_high);
    wire [`RSCC_PC_W-1:0] vec_addr = high_vec ? `RSCC_VEC_HIGH : `RSCC_VEC_LOW;
    wire [`RSCC_PC_W-1:0] ret_pc   = stack_mem[sp_reg - `RSCC_SP_W'(1)];
    wire [`RSCC_PC_W-1:0] pc_seq   = pc_reg + `RSCC_INSTR_BYTES;
    wire [`RSCC_PC_W-1:0] pc_jump  = pc_reg + {{(`RSCC_PC_W-8){1'b0}}, live_ctx.working};

    // register decode
    wire sel_ctrl  = (reg_addr == `RSCC_OFF_CTRL);
    wire sel_stack = (reg_addr == `RSCC_OFF_STACK);
    wire sel_stat  = (reg_addr == `RSCC_OFF_IRQ_STAT);
    wire sel_mask  = (reg_addr == `RSCC_OFF_IRQ_MASK);
    wire sel_pc    = (reg_addr == `RSCC_OFF_PC);
    wire sel_cause = (reg_addr == `RSCC_OFF_CAUSE);
    // reads decode the live address phase, so a write data phase in flight cannot steer them;
    // a read right behind a write to the same register still returns the old value
    wire rsel_ctrl  = (haddr == `RSCC_OFF_CTRL);
    wire rsel_stack = (haddr == `RSCC_OFF_STACK);
    wire rsel_stat  = (haddr == `RSCC_OFF_IRQ_STAT);
    wire rsel_mask  = (haddr == `RSCC_OFF_IRQ_MASK);
    wire rsel_pc    = (haddr == `RSCC_OFF_PC);
    wire rsel_cause = (haddr == `RSCC_OFF_CAUSE);
    // shadow context has no address, so software never reaches it
    wire [31:0] stack_word = {24'h000000, full_reg, unf_reg, 1'b0, sp_reg};
    assign rd_data = rsel_ctrl  ? {31'h0, sfre_reg} :
                     rsel_stack ? stack_word :
                     rsel_stat  ? {29'h0, irq_stat_reg} :
                     rsel_mask  ? {29'h0, irq_mask_reg} :
                     rsel_pc    ? {11'h0, pc_reg} :
                     rsel_cause ? {24'h000000, cause_reg} : 32'h00000000;
    wire stk_wr  = wr_en && sel_stack;
    wire full_clr = stk_wr && !wr_data[`RSCC_BIT_FULL];
    wire unf_clr  = stk_wr && !wr_data[`RSCC_BIT_UNF];
    wire [`RSCC_IRQ_W-1:0] irq_ev  = {wake_vec || op.wake_irq, unf_ev, full_ev};
    wire [`RSCC_IRQ_W-1:0] irq_clr = (wr_en && sel_stat) ? wr_data[`RSCC_IRQ_W-1:0] : {`RSCC_IRQ_W{1'b0}};

    // strap latched on the clock after reset, never through the reset itself
    always_ff @(posedge mclk) begin
        if (reset) begin
            sfre_reg <= 1'b0;
        end else if (wr_en && sel_ctrl) begin
            sfre_reg <= wr_data[0];
        end else if (state_reg == rscc_pkg::RSCC_RESET) begin
            sfre_reg <= stack_fault_reset_enable;
        end
    end

    // fault sequencing: flag first, reset one cycle later
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg    <= rscc_pkg::RSCC_RESET;
            device_reset <= 1'b0;
        end else begin
            case (state_reg)
                rscc_pkg::RSCC_RESET: begin
                    state_reg    <= rscc_pkg::RSCC_RUN;
                    device_reset <= 1'b0;
                end
                rscc_pkg::RSCC_RUN: begin
                    if (fault_ev && sfre_reg) begin
                        state_reg <= rscc_pkg::RSCC_FAULT;
                    end
                    device_reset <= 1'b0;
                end
                rscc_pkg::RSCC_FAULT: begin
                    state_reg    <= rscc_pkg::RSCC_RESET;
                    device_reset <= 1'b1;
                end
                default: begin
                    state_reg    <= rscc_pkg::RSCC_RESET;
                    device_reset <= 1'b0;
                end
            endcase
        end
    end

    // flags survive the device reset they cause; only reset (power-on) or software clear them
    always_ff @(posedge mclk) begin
        if (reset) begin
            full_reg <= 1'b0;
            unf_reg  <= 1'b0;
        end else begin
            full_reg <= full_ev || (full_reg && !full_clr);
            unf_reg  <= unf_ev || (unf_reg && !unf_clr);
        end
    end

    // return stack and program counter
    always_ff @(posedge mclk) begin
        if (reset || state_reg == rscc_pkg::RSCC_RESET) begin
            sp_reg <= `RSCC_SP_RESET;
            pc_reg <= `RSCC_PC_RESET;
        end else if (push && !full_ev) begin
            stack_mem[sp_reg] <= irq_vec ? pc_reg : pc_seq;
            sp_reg            <= sp_reg + `RSCC_SP_W'(1);
            pc_reg            <= irq_vec ? vec_addr : call_target;
        end else if (pop && !unf_ev) begin
            sp_reg <= sp_reg - `RSCC_SP_W'(1);
            pc_reg <= ret_pc;
        end else if (run && op.add_pcl) begin
            pc_reg <= pc_jump;
        end else if (run) begin
            pc_reg <= pc_seq;
        end
    end

    // shadow context: written in the push cycle; later interrupts simply overwrite
    always_ff @(posedge mclk) begin
        if (reset) begin
            shadow_context_stack <= '0;
        end else if (save_ctx) begin
            shadow_context_stack <= live_ctx;
        end
    end

    // restore and literal results toward the core
    always_ff @(posedge mclk) begin
        if (reset) begin
            restore_ctx      <= '0;
            restore_valid    <= 1'b0;
            working_register <= `RSCC_BYTE_RESET;
            working_valid    <= 1'b0;
        end else begin
            restore_valid <= restore;
            if (restore) begin
                restore_ctx <= shadow_context_stack;
            end
            working_valid <= pop && !unf_ev && op.return_with_literal_op;
            if (pop && !unf_ev && op.return_with_literal_op) begin
                working_register <= literal;
            end
        end
    end

    // wake cause kept so at least one bit reports it
    always_ff @(posedge mclk) begin
        if (reset) begin
            cause_reg <= `RSCC_CAUSE_W'(0);
        end else if (op.wake_irq) begin
            cause_reg <= (wake_cause == `RSCC_CAUSE_W'(0)) ? `RSCC_CAUSE_W'(1) : wake_cause;
        end else if (wr_en && sel_cause) begin
            cause_reg <= wr_data[`RSCC_CAUSE_W-1:0];
        end
    end

    // interrupt status: set wins over a write-one clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_stat_reg <= {`RSCC_IRQ_W{1'b0}};
            irq_mask_reg <= {`RSCC_IRQ_W{1'b0}};
            irq          <= 1'b0;
            pc_out       <= `RSCC_PC_RESET;
        end else begin
            irq_stat_reg <= irq_ev | (irq_stat_reg & ~irq_clr);
            if (wr_en && sel_mask) begin
                irq_mask_reg <= wr_data[`RSCC_IRQ_W-1:0];
            end
            irq    <= |(irq_stat_reg & irq_mask_reg);
            pc_out <= pc_reg;
        end
    end
endmodule : rscc_core

//--- sim/rscc_seq_model.sv
// far side model: sequencer registers fed back by fast returns and literal returns
`timescale 1ns/1ps
module rscc_seq_model (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                reset,
    // bench load
    input  wire logic                ld_en,
    input  wire rscc_pkg::rscc_ctx_t ld_ctx,
    // results from the block
    input  wire rscc_pkg::rscc_ctx_t restore_ctx,
    input  wire logic                restore_valid,
    input  wire logic [7:0]          working_register,
    input  wire logic                working_valid,
    // live registers
    output rscc_pkg::rscc_ctx_t      live_ctx
);
    // block results win over bench loads, as the core would retire them
    always_ff @(posedge mclk) begin
        if (reset) begin
            live_ctx <= '0;
        end else if (restore_valid) begin
            live_ctx <= restore_ctx;
        end else if (working_valid) begin
            live_ctx.working <= working_register;
        end else if (ld_en) begin
            live_ctx <= ld_ctx;
        end
    end
endmodule : rscc_seq_model

//--- sim/rscc_core_properties.sv
// port assertions of the return stack context control core
`timescale 1ns/1ps
`include "rscc_map.svh"
module rscc_core_properties (
    // clock and reset
    input wire logic                  mclk,
    input wire logic                  reset,
    // watched ports
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire rscc_pkg::rscc_op_t    op,
    input wire logic [7:0]            literal,
    input wire rscc_pkg::rscc_ctx_t   live_ctx,
    input wire logic [`RSCC_PC_W-1:0] pc_out,
    input wire logic                  restore_valid,
    input wire logic [7:0]            working_register,
    input wire logic                  working_valid,
    input wire logic                  device_reset
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    AST_VEC_HIGH: assert property (op.irq_high |-> ##2 pc_out == `RSCC_VEC_HIGH)
        else $error("high priority vector not loaded");
    AST_VEC_LOW: assert property (op.irq_low |-> ##2 pc_out == `RSCC_VEC_LOW)
        else $error("low priority vector not loaded");
    // pc_out lags, so the step shows two edges after the add
    AST_ADD_PCL: assert property (op.add_pcl |-> ##2 pc_out == $past(pc_out) + {13'h0, $past(live_ctx.working, 2)})
        else $error("computed jump offset not applied");
    AST_RETURN_WITH_LITERAL_OP: assert property (op.return_with_literal_op |=> working_valid && working_register == $past(literal))
        else $error("literal not returned");
    AST_WORK_CAUSE: assert property (working_valid |-> $past(op.return_with_literal_op))
        else $error("working result without literal return");
    AST_FAST_RET: assert property (op.ret_fast |=> restore_valid)
        else $error("fast return gave no context");
    AST_RETURN_FROM_INTERRUPT_OP_FAST: assert property (op.return_from_interrupt_op_fast |=> restore_valid)
        else $error("fast interrupt return gave no context");
    AST_RESTORE_CAUSE: assert property (restore_valid |-> $past(op.ret_fast || op.return_from_interrupt_op_fast))
        else $error("context restored without fast return");
    AST_RESET_PULSE: assert property (device_reset |=> !device_reset)
        else $error("device reset longer than one cycle");
endmodule : rscc_core_properties
bind rscc_core rscc_core_properties i_props (.mclk(mclk), .reset(reset), .hreadyout(hreadyout), .hresp(hresp),
    .op(op), .literal(literal), .live_ctx(live_ctx), .pc_out(pc_out), .restore_valid(restore_valid),
    .working_register(working_register), .working_valid(working_valid), .device_reset(device_reset));

//--- sim/tb_return_stack_context_control.sv
// self-checking bench of the return stack context control core
`timescale 1ns/1ps
`include "rscc_map.svh"
module tb_return_stack_context_control;
    logic                  mclk = 0, reset = 1, hsel = 0, hwrite = 0, ld_en = 0, strap = 0, gie = 1;
    logic [31:0]           haddr = '0, hwdata = '0, hrdata, q;
    logic [1:0]            htrans = '0;
    logic [7:0]            literal = '0, cause = '0, working_register;
    rscc_pkg::rscc_op_t    op = '0;
    rscc_pkg::rscc_ctx_t   ld_ctx = '0, live_ctx, restore_ctx;
    logic                  hreadyout, hresp, restore_valid, working_valid, device_reset, irq;
    logic [`RSCC_PC_W-1:0] pc_out;
    int                    err_count = 0, checks = 0;
    always #10 mclk = ~mclk;
    rscc_core i_dut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .op(op), .literal(literal), .call_target(21'h000100), .live_ctx(live_ctx), .wake_cause(cause),
        .stack_fault_reset_enable(strap), .high_priority_global_enable(gie), .low_priority_global_enable(gie),
        .pc_out(pc_out), .restore_ctx(restore_ctx), .restore_valid(restore_valid),
        .working_register(working_register), .working_valid(working_valid), .device_reset(device_reset), .irq(irq));
    rscc_seq_model i_seq (.mclk(mclk), .reset(reset), .ld_en(ld_en), .ld_ctx(ld_ctx), .restore_ctx(restore_ctx),
        .restore_valid(restore_valid), .working_register(working_register), .working_valid(working_valid),
        .live_ctx(live_ctx));
    task automatic print_verdict;
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // levels are taken at the rising edge, before that edge's own updates land
    task automatic wt(input logic dr);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while ((dr ? device_reset : hreadyout) !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            print_verdict;
        end
    endtask : wt
    // one idle cycle after each transfer, since a read right behind a write sees the old value
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wt(1'b0);
        htrans <= 2'h0;
        hwdata <= d;
        wt(1'b0);
        q = hrdata;
        @(posedge mclk);
    endtask : bus
    // an all-zero op passes one idle edge, so op is never driven twice at once
    task automatic do_op(input logic [11:0] v, input rscc_pkg::rscc_ctx_t c, input logic l);
        op <= v;
        ld_ctx <= c;
        ld_en <= l;
        @(posedge mclk);
    endtask : do_op
    task automatic irq_chk(input logic e);
        @(posedge mclk);
        chk(irq, e);
    endtask : irq_chk
    task automatic t_reset;
        bus(1'b0, `RSCC_OFF_STACK, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, `RSCC_OFF_IRQ_STAT, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 32'h00000040, 32'hFFFFFFFF);
        bus(1'b0, 32'h00000040, 32'h0);
        chk(q, 32'h0);
        chk(irq, 1'b0);
    endtask : t_reset
    task automatic t_shadow;
        cause <= 8'h04;
        do_op(12'h000, 24'h112233, 1'b1);
        do_op(12'h003, '0, 1'b0);
        do_op(12'h000, '0, 1'b0);
        do_op(12'h000, '0, 1'b0);
        chk(pc_out, `RSCC_VEC_HIGH);
        bus(1'b0, `RSCC_OFF_CAUSE, 32'h0);
        chk(q, 32'h04);
        bus(1'b0, `RSCC_OFF_IRQ_STAT, 32'h0);
        chk(q & 32'h4, 32'h4);
        // a wake with both enables clear must not push
        gie <= 1'b0;
        do_op(12'h002, '0, 1'b0);
        gie <= 1'b1;
        do_op(12'h000, '0, 1'b0);
        bus(1'b0, `RSCC_OFF_STACK, 32'h0);
        chk(q & 32'h1F, 32'h1);
        do_op(12'h000, 24'h445566, 1'b1);
        do_op(12'h004, '0, 1'b0);
        do_op(12'h000, '0, 1'b0);
        do_op(12'h000, '0, 1'b0);
        chk(pc_out, `RSCC_VEC_LOW);
        // a different live value proves the restore comes from the shadow copy
        do_op(12'h040, 24'h778899, 1'b1);
        do_op(12'h000, '0, 1'b0);
        chk(restore_ctx, 24'h445566);
        do_op(12'h000, '0, 1'b0);
        chk(live_ctx, 24'h445566);
        bus(1'b1, `RSCC_OFF_IRQ_STAT, 32'h4);
    endtask : t_shadow
    task automatic t_fast_call;
        do_op(12'h000, 24'hA55AC3, 1'b1);
        do_op(12'h400, 24'h0FF099, 1'b1);
        do_op(12'h100, '0, 1'b0);
        do_op(12'h000, '0, 1'b0);
        chk(restore_ctx, 24'hA55AC3);
        do_op(12'h000, '0, 1'b0);
        chk(live_ctx, 24'hA55AC3);
    endtask : t_fast_call
    task automatic t_table;
        do_op(12'h000, 24'h000600, 1'b1);
        do_op(12'h008, '0, 1'b0);
        do_op(12'h010, '0, 1'b0);
        do_op(12'h000, '0, 1'b0);
        do_op(12'h000, '0, 1'b0);
        chk(pc_out, 21'h00000E);
        literal <= 8'h5A;
        do_op(12'h020, '0, 1'b0);
        do_op(12'h000, '0, 1'b0);
        chk(working_valid, 1'b1);
        do_op(12'h000, '0, 1'b0);
        chk(live_ctx.working, 8'h5A);
    endtask : t_table
    task automatic t_underflow;
        bus(1'b1, `RSCC_OFF_CTRL, 32'h1);
        do_op(12'h080, '0, 1'b0);
        do_op(12'h200, '0, 1'b0);
        do_op(12'h000, '0, 1'b0);
        wt(1'b1);
        chk(device_reset, 1'b1);
        bus(1'b0, `RSCC_OFF_STACK, 32'h0);
        chk(q & 32'hC0, 32'h40);
        bus(1'b0, `RSCC_OFF_IRQ_STAT, 32'h0);
        chk(q & 32'h3, 32'h2);
        // a mask bit of one lets its status bit through to irq
        irq_chk(1'b0);
        bus(1'b1, `RSCC_OFF_IRQ_MASK, 32'h7);
        irq_chk(1'b1);
        bus(1'b1, `RSCC_OFF_IRQ_STAT, 32'h3);
        irq_chk(1'b0);
        bus(1'b1, `RSCC_OFF_IRQ_MASK, 32'h0);
    endtask : t_underflow
    // strap low is relatched by the device reset, so the full push must not reset
    task automatic t_full;
        repeat (32) do_op(12'h800, '0, 1'b0);
        do_op(12'h000, '0, 1'b0);
        repeat (4) begin
            @(posedge mclk);
            chk(device_reset, 1'b0);
        end
        bus(1'b0, `RSCC_OFF_STACK, 32'h0);
        chk(q & 32'hC0, 32'hC0);
        bus(1'b1, `RSCC_OFF_STACK, 32'h0);
        bus(1'b0, `RSCC_OFF_STACK, 32'h0);
        chk(q & 32'hC0, 32'h0);
    endtask : t_full
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        t_reset;
        t_shadow;
        t_fast_call;
        t_table;
        t_underflow;
        t_full;
        print_verdict;
    end
endmodule : tb_return_stack_context_control
